// [hw/sfpb_top.sv]
// Notes on behaviour
// - Page read: opcode D2H, three address bytes, four dummy bytes.
// - 528-byte mode: page is address bits 22..10, start byte bits 9..0.
// - 512-byte mode: page is address bits 21..9, start byte bits 8..0.
// - After the dummy bytes, one data bit leaves per serial clock.
// - Page read wraps from the last byte to byte zero of the same page.
// - Chip select rising ends any read and floats serial output.
// - Page read never writes either SRAM buffer.
// - D4H and D1H read buffer 1; D6H and D3H read buffer 2.
// - Buffer read address: low 10 bits (528) or 9 bits (512) used.
// - Exactly one dummy byte before buffer read data.
// - Buffer read wraps from the last byte to byte zero.
// - 84H writes buffer 1, 87H buffer 2, from the given start byte.
// - Written bytes go to successive locations, wrapping to zero.
// - Buffer loading continues until chip select rises.
// - 83H and 86H program page from buffer 1 or 2 with erase.
// - Program page number taken from the same bits as a page read.
// - With erase: at chip select rise erase page, then program it.
// - 88H and 89H program from buffer 1 or 2 without erase.
// - Busy shows on status and ready/busy output during programming.
// - Serial clock modes 0 and 3; clock may idle either level.
`timescale 1ns/1ps
module sfpb_top (
  input wire logic clk, // System clock, 100 MHz
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic cs_n, // Chip select pin, active low
  input wire logic sck, // Serial clock pin
  input wire logic si, // Serial data in pin
  output logic so, // Serial data out
  output logic so_oe_n, // Serial out enable, low while driving
  output logic ready_busy_out, // High ready, low busy
  output logic status_busy, // Busy bit for the status register
  input wire logic page_512, // Page size 512 when high, else 528
  output logic [sfpb_pkg::PAGE_BITS-1:0] mem_rd_page, // Array read page
  output logic [sfpb_pkg::IDX_BITS-1:0] mem_rd_byte, // Array read byte
  input wire logic [7:0] mem_rd_data, // Array read data
  output logic mem_prog_start, // One-cycle program start
  output logic mem_prog_erase, // Erase page before program
  output logic [sfpb_pkg::PAGE_BITS-1:0] mem_prog_page, // Program page
  output logic mem_wr_valid, // Program byte valid
  output logic [7:0] mem_wr_data, // Program byte
  input wire logic mem_wr_ready, // Array takes program byte
  input wire logic mem_prog_done // Array finished program, pulse
);
  import sfpb_pkg::*;

  typedef struct packed {
    logic [2:0] sck_s;
    logic [2:0] cs_s;
    logic [2:0] si_s;
    logic sck_lvl;
    logic cs_lvl;
    sfpb_link_e link;
    logic [2:0] bitcnt;
    logic [2:0] bytecnt;
    logic [2:0] dummy_last;
    logic [6:0] shreg;
    logic [7:0] opcode;
    logic [15:0] addr;
    logic is_main;
    logic rd_buf;
    logic [IDX_BITS-1:0] rd_idx;
    logic [PAGE_BITS-1:0] rd_page;
    logic wr_buf;
    logic [IDX_BITS-1:0] wr_idx;
    logic so;
    logic so_oe_n;
    sfpb_prog_e prog;
    logic prog_buf;
    logic prog_erase;
    logic [PAGE_BITS-1:0] prog_page;
    logic prog_start;
    logic [IDX_BITS-1:0] prog_idx;
    logic ready;
    logic busy;
    logic skid_valid;
    logic [7:0] skid_data;
    logic out_valid;
    logic [7:0] out_data;
  } sfpb_state_s;

  // ==========================================
  // Decoding helpers
  function automatic logic [IDX_BITS-1:0] last_idx(input logic p512);
    last_idx = p512 ? LAST_IDX_512 : LAST_IDX_528;
  endfunction

  function automatic logic [IDX_BITS-1:0] step_idx(input logic [IDX_BITS-1:0] idx,
                                                   input logic p512);
    step_idx = (idx == last_idx(p512)) ? '0 : idx + 10'h001;
  endfunction

  function automatic logic [PAGE_BITS-1:0] page_of(input logic [23:0] a, input logic p512);
    page_of = p512 ? a[PAGE_LSB_512 +: PAGE_BITS] : a[PAGE_LSB_528 +: PAGE_BITS];
  endfunction

  function automatic logic [IDX_BITS-1:0] col_of(input logic [23:0] a, input logic p512);
    col_of = p512 ? {1'b0, a[PAGE_LSB_512-1:0]} : a[PAGE_LSB_528-1:0];
  endfunction

  // ==========================================
  // Reset release
  logic [1:0] rst_q;
  logic rst_n;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rst_q <= 2'h0;
    else
      rst_q <= {rst_q[0], 1'b1};
  end
  assign rst_n = rst_q[1];

  sfpb_state_s st;
  sfpb_state_s n;
  logic [7:0] buf_mem [2][BUF_DEPTH];
  logic bw_en;
  logic bw_sel;
  logic [IDX_BITS-1:0] bw_addr;
  logic [7:0] bw_data;

  // Edges count only once the second and third stages agree
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic cs_fall;
  logic byte_done;
  logic [7:0] byte_in;
  logic [23:0] addr_full;
  logic [7:0] rd_byte;
  logic rd_bit;
  assign sck_rise = (st.sck_s[1] == st.sck_s[2]) && st.sck_s[2] && !st.sck_lvl;
  assign sck_fall = (st.sck_s[1] == st.sck_s[2]) && !st.sck_s[2] && st.sck_lvl;
  assign cs_rise = (st.cs_s[1] == st.cs_s[2]) && st.cs_s[2] && !st.cs_lvl;
  assign cs_fall = (st.cs_s[1] == st.cs_s[2]) && !st.cs_s[2] && st.cs_lvl;
  assign byte_done = sck_rise && (st.bitcnt == 3'h7);
  assign byte_in = {st.shreg, st.si_s[2]};
  assign addr_full = {st.addr, byte_in};
  // Main array data must settle within a few clocks of a new address
  assign rd_byte = st.is_main ? mem_rd_data : buf_mem[st.rd_buf][st.rd_idx];
  assign rd_bit = rd_byte[~st.bitcnt];

  always_comb
  begin
    n = st;
    bw_en = 1'b0;
    bw_sel = st.wr_buf;
    bw_addr = st.wr_idx;
    bw_data = byte_in;
    n.sck_s = {st.sck_s[1:0], sck};
    n.cs_s = {st.cs_s[1:0], cs_n};
    n.si_s = {st.si_s[1:0], si};
    if (st.sck_s[1] == st.sck_s[2])
      n.sck_lvl = st.sck_s[2];
    if (st.cs_s[1] == st.cs_s[2])
      n.cs_lvl = st.cs_s[2];
    n.prog_start = 1'b0;
    // ==========================================
    // Two-entry program buffer; a stalled array holds the engine
    if (!st.out_valid || mem_wr_ready)
    begin
      if (st.skid_valid)
      begin
        n.out_valid = 1'b1;
        n.out_data = st.skid_data;
        n.skid_valid = 1'b0;
      end
      else
      begin
        n.out_valid = 1'b0;
      end
    end
    // ==========================================
    // Self-timed program engine
    case (st.prog)
      P_IDLE:
      begin
        n.busy = 1'b0;
      end
      P_STREAM:
      begin
        if (!st.skid_valid)
        begin
          if (!st.out_valid || mem_wr_ready)
          begin
            n.out_valid = 1'b1;
            n.out_data = buf_mem[st.prog_buf][st.prog_idx];
          end
          else
          begin
            n.skid_valid = 1'b1;
            n.skid_data = buf_mem[st.prog_buf][st.prog_idx];
          end
          n.prog_idx = step_idx(st.prog_idx, page_512);
          if (st.prog_idx == last_idx(page_512))
            n.prog = P_WAIT;
        end
      end
      P_WAIT:
      begin
        if (mem_prog_done)
        begin
          n.prog = P_IDLE;
          n.ready = 1'b1;
          n.busy = 1'b0;
        end
      end
      default:
        n.prog = P_IDLE;
    endcase
    // ==========================================
    // Serial link
    if (sck_rise)
    begin
      n.bitcnt = st.bitcnt + 3'h1;
      n.shreg = byte_in[6:0];
    end
    if (cs_rise)
    begin
      n.link = L_IDLE;
      n.so_oe_n = 1'b1;
      if (st.link == L_ARMED && st.prog == P_IDLE)
      begin
        n.prog = P_STREAM;
        n.prog_start = 1'b1;
        n.prog_idx = '0;
        n.ready = 1'b0;
        n.busy = 1'b1;
      end
    end
    else if (cs_fall)
    begin
      n.link = L_CMD;
      n.bitcnt = 3'h0;
      n.so_oe_n = 1'b1;
    end
    else
    begin
      case (st.link)
        L_CMD:
        begin
          if (byte_done)
          begin
            n.opcode = byte_in;
            n.bytecnt = 3'h0;
            case (byte_in)
              OP_PAGE_READ, OP_BUF1_RD_FAST, OP_BUF1_RD_SLOW, OP_BUF2_RD_FAST,
              OP_BUF2_RD_SLOW, OP_BUF1_WR, OP_BUF2_WR, OP_BUF1_PGM_ERASE,
              OP_BUF2_PGM_ERASE, OP_BUF1_PGM, OP_BUF2_PGM:
                n.link = L_ADDR;
              default:
                n.link = L_SKIP;
            endcase
          end
        end
        L_ADDR:
        begin
          if (byte_done)
          begin
            n.addr = addr_full[15:0];
            n.bytecnt = st.bytecnt + 3'h1;
            if (st.bytecnt == ADDR_LAST_BYTE)
            begin
              n.bytecnt = 3'h0;
              n.rd_idx = col_of(addr_full, page_512);
              n.rd_page = page_of(addr_full, page_512);
              n.prog_page = page_of(addr_full, page_512);
              n.wr_idx = col_of(addr_full, page_512);
              n.is_main = 1'b0;
              n.link = L_SKIP;
              case (st.opcode)
                OP_PAGE_READ:
                begin
                  n.is_main = 1'b1;
                  n.dummy_last = PAGE_RD_DUMMY_LAST;
                  n.link = L_DUMMY;
                end
                OP_BUF1_RD_FAST, OP_BUF1_RD_SLOW, OP_BUF2_RD_FAST, OP_BUF2_RD_SLOW:
                begin
                  // Both speeds decode the same; the clock limit is the host's
                  n.rd_buf = (st.opcode == OP_BUF2_RD_FAST)
                           || (st.opcode == OP_BUF2_RD_SLOW);
                  n.dummy_last = BUF_RD_DUMMY_LAST;
                  n.link = L_DUMMY;
                end
                OP_BUF1_WR, OP_BUF2_WR:
                begin
                  n.wr_buf = (st.opcode == OP_BUF2_WR);
                  n.link = L_WDATA;
                end
                OP_BUF1_PGM_ERASE, OP_BUF2_PGM_ERASE, OP_BUF1_PGM, OP_BUF2_PGM:
                begin
                  n.prog_buf = (st.opcode == OP_BUF2_PGM_ERASE)
                             || (st.opcode == OP_BUF2_PGM);
                  n.prog_erase = (st.opcode == OP_BUF1_PGM_ERASE)
                               || (st.opcode == OP_BUF2_PGM_ERASE);
                  n.link = L_ARMED;
                end
                default:
                  n.link = L_SKIP;
              endcase
            end
          end
        end
        L_DUMMY:
        begin
          if (byte_done)
          begin
            n.bytecnt = st.bytecnt + 3'h1;
            if (st.bytecnt == st.dummy_last)
            begin
              n.link = L_RDATA;
              n.so_oe_n = 1'b0;
              n.so = rd_byte[7];
            end
          end
        end
        L_RDATA:
        begin
          if (sck_fall)
            n.so = rd_bit;
          if (byte_done)
            n.rd_idx = step_idx(st.rd_idx, page_512);
        end
        L_WDATA:
        begin
          if (byte_done)
          begin
            bw_en = 1'b1;
            n.wr_idx = step_idx(st.wr_idx, page_512);
          end
        end
        L_ARMED, L_SKIP, L_IDLE:
        begin
          n.link = st.link;
        end
        default:
          n.link = L_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.cs_s <= SYNC_HIGH;
      st.cs_lvl <= 1'b1;
      st.so_oe_n <= 1'b1;
      st.ready <= 1'b1;
    end
    else
    begin
      st <= n;
    end
  end

  // Buffers are plain RAM; contents are undefined until written
  always_ff @(posedge clk)
  begin
    if (bw_en)
      buf_mem[bw_sel][bw_addr] <= bw_data;
  end

  assign so = st.so;
  assign so_oe_n = st.so_oe_n;
  assign ready_busy_out = st.ready;
  assign status_busy = st.busy;
  assign mem_rd_page = st.rd_page;
  assign mem_rd_byte = st.rd_idx;
  assign mem_prog_start = st.prog_start;
  assign mem_prog_erase = st.prog_erase;
  assign mem_prog_page = st.prog_page;
  assign mem_wr_valid = st.out_valid;
  assign mem_wr_data = st.out_data;

  // ==========================================
  // Checks
  logic addr_end;
  assign addr_end = (st.link == L_ADDR) && byte_done && !cs_rise && !cs_fall
                    && (st.bytecnt == ADDR_LAST_BYTE);

  sequence s_armed_close;
    (st.link == L_ARMED) && cs_rise && (st.prog == P_IDLE);
  endsequence
  sequence s_prog_begins;
    st.prog_start && !st.ready && st.busy;
  endsequence

  a_page_read_dummy: assert property (@(posedge clk) disable iff (!rst_n)
    addr_end && st.opcode == OP_PAGE_READ |=> st.link == L_DUMMY
    && st.dummy_last == PAGE_RD_DUMMY_LAST && st.is_main)
    else $error("page read did not enter four dummy bytes");
  a_page_528_decode: assert property (@(posedge clk) disable iff (!rst_n)
    addr_end && !page_512 |=> mem_rd_page == $past(addr_full[22:10])
    && mem_rd_byte == $past(addr_full[9:0]))
    else $error("528 mode address split wrong");
  a_page_512_decode: assert property (@(posedge clk) disable iff (!rst_n)
    addr_end && page_512 |=> mem_rd_page == $past(addr_full[21:9])
    && mem_rd_byte == {1'b0, $past(addr_full[8:0])})
    else $error("512 mode address split wrong");
  a_read_bit_out: assert property (@(posedge clk) disable iff (!rst_n)
    st.link == L_RDATA && sck_fall && !cs_rise && !cs_fall |=> so == $past(rd_bit) && !so_oe_n)
    else $error("read bit not driven on falling clock");
  a_read_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    st.link == L_RDATA && byte_done && !cs_rise && !cs_fall
    && st.rd_idx == last_idx(page_512) |=> mem_rd_byte == '0)
    else $error("read did not wrap to byte zero");
  a_cs_float: assert property (@(posedge clk) disable iff (!rst_n)
    cs_rise |=> so_oe_n [*2])
    else $error("serial output not floated after deselect");
  a_read_no_write: assert property (@(posedge clk) disable iff (!rst_n)
    st.is_main && st.link != L_WDATA |-> !bw_en)
    else $error("buffer written during page read");
  a_buffer_select: assert property (@(posedge clk) disable iff (!rst_n)
    addr_end && (st.opcode == OP_BUF2_RD_SLOW || st.opcode == OP_BUF2_RD_FAST)
    |=> st.rd_buf && st.link == L_DUMMY && st.dummy_last == BUF_RD_DUMMY_LAST)
    else $error("buffer 2 read decoded wrong");
  a_write_store: assert property (@(posedge clk) disable iff (!rst_n)
    st.link == L_WDATA && byte_done && !cs_rise && !cs_fall
    |-> bw_en && bw_addr == st.wr_idx ##1 st.wr_idx == step_idx($past(st.wr_idx), page_512))
    else $error("write byte not stored at next location");
  a_prog_kind: assert property (@(posedge clk) disable iff (!rst_n)
    s_armed_close |=> s_prog_begins and (mem_prog_erase == $past(st.prog_erase)))
    else $error("program start or erase choice wrong");
  a_busy_hold: assert property (@(posedge clk) disable iff (!rst_n)
    st.prog != P_IDLE |-> !ready_busy_out && status_busy)
    else $error("ready shown during programming");
endmodule

// [hw/sfpb_pkg.sv]
package sfpb_pkg;
  // ==========================================
  // Command opcodes
  localparam logic [7:0] OP_PAGE_READ = 8'hD2;
  localparam logic [7:0] OP_BUF1_RD_FAST = 8'hD4;
  localparam logic [7:0] OP_BUF1_RD_SLOW = 8'hD1;
  localparam logic [7:0] OP_BUF2_RD_FAST = 8'hD6;
  localparam logic [7:0] OP_BUF2_RD_SLOW = 8'hD3;
  localparam logic [7:0] OP_BUF1_WR = 8'h84;
  localparam logic [7:0] OP_BUF2_WR = 8'h87;
  localparam logic [7:0] OP_BUF1_PGM_ERASE = 8'h83;
  localparam logic [7:0] OP_BUF2_PGM_ERASE = 8'h86;
  localparam logic [7:0] OP_BUF1_PGM = 8'h88;
  localparam logic [7:0] OP_BUF2_PGM = 8'h89;
  // ==========================================
  // Frame layout and geometry
  localparam logic [2:0] ADDR_LAST_BYTE = 3'h2;
  localparam logic [2:0] PAGE_RD_DUMMY_LAST = 3'h3;
  localparam logic [2:0] BUF_RD_DUMMY_LAST = 3'h0;
  localparam int PAGE_BITS = 13;
  localparam int IDX_BITS = 10;
  localparam int BUF_DEPTH = 528;
  localparam logic [9:0] LAST_IDX_528 = 10'h20F;
  localparam logic [9:0] LAST_IDX_512 = 10'h1FF;
  localparam int PAGE_LSB_528 = 10;
  localparam int PAGE_LSB_512 = 9;
  // ==========================================
  // Reset values
  localparam logic [2:0] SYNC_HIGH = 3'h7;
  // ==========================================
  // State types
  typedef enum logic [2:0] {
    L_IDLE, L_CMD, L_ADDR, L_DUMMY, L_RDATA, L_WDATA, L_ARMED, L_SKIP
  } sfpb_link_e;
  typedef enum logic [1:0] {P_IDLE, P_STREAM, P_WAIT} sfpb_prog_e;
endpackage

// [test/sfpb_host.sv]
`timescale 1ns/1ps
module sfpb_host (
  input wire logic clk, // System clock
  input wire logic so, // Device serial out
  input wire logic so_oe_n, // Low while device drives so
  output logic cs_n, // Chip select, active low
  output logic sck, // Serial clock, 160 ns period
  output logic si // Serial data in
);
  logic idle_hi = 1'h0;
  initial cs_n = 1'h1;
  initial sck = 1'h0;
  initial si = 1'h0;
  // ==========================================
  // Frame tasks
  task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      sck <= 1'h0;
      si <= tx[i];
      repeat (8) @(posedge clk);
      sck <= 1'h1;
      // A floating pin reads as z so a missing drive never matches
      #1 rx[i] = so_oe_n ? 1'hz : so;
      repeat (8) @(posedge clk);
    end
  endtask
  task automatic head(input logic m3, input logic [7:0] op, input logic [23:0] a,
                      input int nd);
    logic [7:0] r;
    @(posedge clk);
    idle_hi = m3;
    sck <= m3;
    repeat (8) @(posedge clk);
    cs_n <= 1'h0;
    repeat (8) @(posedge clk);
    shift(op, r);
    for (int i = 2; i >= 0; i--)
      shift(a[i*8 +: 8], r);
    repeat (nd) shift(8'h5A, r);
  endtask
  task automatic end_frame;
    if (!idle_hi)
      sck <= 1'h0;
    repeat (8) @(posedge clk);
    cs_n <= 1'h1;
    si <= ~si;
    @(posedge clk);
  endtask
endmodule

// [test/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import sfpb_pkg::*;
  typedef struct packed {
    logic [7:0] wop;
    logic [7:0] rop;
    logic [9:0] idx;
    logic p512;
    logic [7:0] seed;
  } sfpb_row_s;
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic page_512 = 1'h0;
  logic mem_wr_ready = 1'h0;
  logic mem_prog_done = 1'h0;
  logic cs_n, sck, si, so, so_oe_n, ready_busy_out, status_busy;
  logic mem_prog_start, mem_prog_erase, mem_wr_valid;
  logic [12:0] mem_rd_page, mem_prog_page, pg;
  logic [9:0] mem_rd_byte, st;
  logic [7:0] mem_rd_data, mem_wr_data, rx;
  logic [7:0] got [8];
  int fail_count = 0;
  int n_tests = 0;
  int n_acc = 0;
  int prog_n = 0;
  int cyc = 0;
  sfpb_row_s rows [4];

  always #5 clk = ~clk;

  sfpb_top i_dut (.clk(clk), .resetn(resetn), .cs_n(cs_n), .sck(sck), .si(si),
    .so(so), .so_oe_n(so_oe_n), .ready_busy_out(ready_busy_out),
    .status_busy(status_busy), .page_512(page_512), .mem_rd_page(mem_rd_page),
    .mem_rd_byte(mem_rd_byte), .mem_rd_data(mem_rd_data),
    .mem_prog_start(mem_prog_start), .mem_prog_erase(mem_prog_erase),
    .mem_prog_page(mem_prog_page), .mem_wr_valid(mem_wr_valid),
    .mem_wr_data(mem_wr_data), .mem_wr_ready(mem_wr_ready),
    .mem_prog_done(mem_prog_done));
  sfpb_host i_host (.clk(clk), .so(so), .so_oe_n(so_oe_n), .cs_n(cs_n),
    .sck(sck), .si(si));

  // ==========================================
  // Array model
  function automatic logic [7:0] md(input logic [12:0] p, input logic [9:0] b);
    return p[7:0] ^ b[7:0] ^ {6'h00, b[9:8]};
  endfunction
  assign mem_rd_data = md(mem_rd_page, mem_rd_byte);
  // Sink stalls one cycle in four so the stream must hold under backpressure
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    mem_wr_ready <= (cyc % 4) != 3;
    mem_prog_done <= 1'h0;
    if (mem_prog_start)
      n_acc <= 0;
    else if (mem_wr_valid && mem_wr_ready)
    begin
      if (n_acc < 8)
        got[n_acc] <= mem_wr_data;
      n_acc <= n_acc + 1;
      mem_prog_done <= (n_acc + 1 == prog_n);
    end
  end

  // ==========================================
  // Checking and closing
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic guard(input logic ok);
    if (!ok)
    begin
      fail_count++;
      $display("BAD t=%0t wait ran out", $time);
      close_out();
    end
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========================================
  // Operations
  task automatic rd(input logic [7:0] op, input logic [23:0] a, input logic [7:0] e,
                    input int n);
    i_host.head(1'h0, op, a, 1);
    for (int k = 0; k < n; k++)
    begin
      i_host.shift(8'h3C, rx);
      check(rx, e + 8'(k));
    end
    check(so_oe_n, 1'h0);
    i_host.end_frame();
    repeat (8) @(posedge clk);
    check(so_oe_n, 1'h1);
  endtask
  task automatic wr_rd(input sfpb_row_s r);
    logic [23:0] a;
    @(posedge clk);
    page_512 <= r.p512;
    // Don't-care address bits are set so that any use of them shows
    a = (r.p512 ? 24'hABCE00 : 24'hABCC00) | {14'h0000, r.idx};
    i_host.head(1'h0, r.wop, a, 0);
    for (int k = 0; k < 4; k++)
      i_host.shift(r.seed + 8'(k), rx);
    i_host.end_frame();
    rd(r.rop, a, r.seed, 4);
    $display("row %h done", r.wop);
  endtask
  task automatic prog(input logic [7:0] op, input logic p, input logic [12:0] g,
                      input logic ers, input logic [7:0] e0, input int ei,
                      input logic [7:0] e);
    int k;
    @(posedge clk);
    page_512 <= p;
    prog_n = p ? 512 : 528;
    i_host.head(1'h0, op, p ? {2'h3, g, 9'h1FF} : {1'h1, g, 10'h3FF}, 0);
    i_host.end_frame();
    for (k = 0; k < 50 && mem_prog_start !== 1'h1; k++)
      @(posedge clk) #1;
    guard(k < 50);
    check(mem_prog_erase, ers);
    check(mem_prog_page, g);
    check({ready_busy_out, status_busy}, 2'h1);
    for (k = 0; k < 3000 && ready_busy_out !== 1'h1; k++)
      @(posedge clk) #1;
    guard(k < 3000);
    check(status_busy, 1'h0);
    check(16'(n_acc), 16'(prog_n));
    check(got[0], e0);
    check(got[ei], e);
    $display("program %h done", op);
  endtask

  // ==========================================
  // Main sequence
  initial
  begin
    rows[0] = '{OP_BUF1_WR, OP_BUF1_RD_FAST, 10'h005, 1'h0, 8'h10};
    rows[1] = '{OP_BUF2_WR, OP_BUF2_RD_FAST, 10'h020, 1'h0, 8'h20};
    // Slow read opcodes are only used with the slow 160 ns serial clock
    rows[2] = '{OP_BUF1_WR, OP_BUF1_RD_SLOW, 10'h1FF, 1'h1, 8'h30};
    rows[3] = '{OP_BUF2_WR, OP_BUF2_RD_SLOW, 10'h20F, 1'h0, 8'h40};
    repeat (5) @(posedge clk);
    check({so_oe_n, ready_busy_out, status_busy, mem_prog_start}, 4'hC);
    resetn <= 1'h1;
    repeat (8) @(posedge clk);
    $display("reset done");
    foreach (rows[i])
      wr_rd(rows[i]);
    for (int m = 0; m < 2; m++)
    begin
      @(posedge clk);
      page_512 <= m[0];
      pg = m ? 13'h1555 : 13'h0ABC;
      st = m ? 10'h1FE : 10'h20E;
      i_host.head(m[0], OP_PAGE_READ, m ? {2'h1, pg, st[8:0]} : {1'h1, pg, st}, 4);
      for (int k = 0; k < 4; k++)
      begin
        i_host.shift(8'hC3, rx);
        check(rx, md(pg, 10'((st + k) % (m ? 512 : 528))));
      end
      check(mem_rd_page, pg);
      i_host.end_frame();
      $display("page read %0d done", m);
    end
    rd(OP_BUF2_RD_FAST, 24'h000000, 8'h41, 3);
    rd(OP_BUF1_RD_FAST, 24'h000000, 8'h31, 3);
    prog(OP_BUF1_PGM_ERASE, 1'h0, 13'h0123, 1'h1, 8'h31, 5, 8'h10);
    prog(OP_BUF2_PGM_ERASE, 1'h1, 13'h1FED, 1'h1, 8'h41, 2, 8'h43);
    // The array model never stores programmed data, so no-erase programs need no blank page
    prog(OP_BUF1_PGM, 1'h1, 13'h0F0F, 1'h0, 8'h31, 5, 8'h10);
    prog(OP_BUF2_PGM, 1'h0, 13'h1000, 1'h0, 8'h41, 2, 8'h43);
    i_host.head(1'h1, OP_BUF1_RD_FAST, 24'h000000, 1);
    i_host.shift(8'h00, rx);
    resetn <= 1'h0;
    repeat (2) @(posedge clk);
    check({so_oe_n, ready_busy_out, status_busy}, 3'h6);
    resetn <= 1'h1;
    i_host.end_frame();
    repeat (8) @(posedge clk);
    check(so_oe_n, 1'h1);
    $display("mid-frame reset done");
    close_out();
  end
endmodule
